// ===== hw/pwp_pkg.sv
/*
  package for the peripheral write protect controller: register offsets,
  bit positions, reset values and the bus carrier structs.
  assumes an AXI4-Lite master with 32-bit data.
*/
package pwp_pkg;
  // byte offsets inside each group window
  localparam logic [3:0] PWP_OFF_CLEAR = 4'h0;
  localparam logic [3:0] PWP_OFF_SET = 4'h4;
  // group windows, chosen by address bits 5:4
  localparam logic [1:0] PWP_GRP0 = 2'h0;
  localparam logic [1:0] PWP_GRP1 = 2'h1;
  localparam logic [1:0] PWP_GRP2 = 2'h2;
  // group 0 bit positions
  localparam int PWP_G0_EXT_IRQ = 6;
  localparam int PWP_G0_RTC = 5;
  localparam int PWP_G0_WATCHDOG = 4;
  localparam int PWP_G0_CLK_GEN = 3;
  localparam int PWP_G0_SYS_CTRL = 2;
  localparam int PWP_G0_POWER_MGR = 1;
  // group 1 bit positions
  localparam int PWP_G1_TRACE_BUF = 6;
  localparam int PWP_G1_IO_PINS = 3;
  localparam int PWP_G1_FLASH_CTRL = 2;
  localparam int PWP_G1_DEBUG_UNIT = 1;
  // group 2 bit positions
  localparam int PWP_G2_CONVERTER = 16;
  localparam int PWP_G2_TIMER_HI = 15;
  localparam int PWP_G2_TIMER_LO = 8;
  localparam int PWP_G2_SERIAL_HI = 7;
  localparam int PWP_G2_SERIAL_LO = 2;
  localparam int PWP_G2_EVENT_ROUTING = 1;
  // implemented-bit masks and reset values
  localparam logic [31:0] PWP_G0_MASK = 32'h0000007E;
  localparam logic [31:0] PWP_G1_MASK = 32'h0000004E;
  localparam logic [31:0] PWP_G2_MASK = 32'h0001FFFE;
  localparam logic [31:0] PWP_G0_RESET = 32'h00000000;
  localparam logic [31:0] PWP_G1_RESET = 32'h00000002;
  localparam logic [31:0] PWP_G2_RESET = 32'h00000000;
  localparam logic [1:0] PWP_RESP_OKAY = 2'h0;
  localparam logic [1:0] PWP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } pwp_rd_t;

  typedef struct packed {
    logic clr;
    logic set;
    logic [31:0] data;
  } pwp_wr_t;
endpackage

// ===== hw/pwp_group.sv
/*
  one protection group: a set of sticky protect bits changed by
  write-one-to-set and write-one-to-clear strobes.
  assumes one strobe pair per cycle from the bus slave.
*/
`timescale 1ns/1ns
`default_nettype none
module pwp_group #(
  parameter logic [31:0] MASK = 32'h0,
  parameter logic [31:0] RESET_VAL = 32'h0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write strobes
  input wire pwp_pkg::pwp_wr_t wr,
  // state
  output logic [31:0] prot
);
  logic [31:0] prot_q;
  logic [31:0] prot_d;

  // zero bits keep their state; unimplemented bits stay zero
  always_comb begin
    prot_d = prot_q;
    if (wr.clr) begin
      prot_d = prot_d & ~(wr.data & MASK);
    end
    if (wr.set) begin
      prot_d = prot_d | (wr.data & MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prot_q <= RESET_VAL;
    end else begin
      prot_q <= prot_d;
    end
  end

  assign prot = prot_q;
endmodule // pwp_group
`default_nettype wire

// ===== hw/pwp_ctrl.sv
/*
  peripheral write protect controller with three protection groups
  reached over AXI4-Lite; group windows are 16 bytes apart.
  assumes one clock, synchronous active-low reset, and a master that
  keeps valid and payload stable until taken.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - group0 bits: ext irq 6 through power 1
// - group0 clear at 0x00, resets to zero
// - writing zero leaves protection unchanged
// - clear write removes; read shows protection
// - group1 bits: trace 6, pins 3, flash 2, debug 1
// - group1 clear at 0x00, resets 0x000002
// - group1 set at 0x04, same layout
// - group2: converter 16, timers 15..8
// - group2: serial 7..2, event routing 1
module pwp_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protection state to the peripherals
  output logic [31:0] prot_group0,
  output logic [31:0] prot_group1,
  output logic [31:0] prot_group2
);
  typedef enum logic [1:0] {PWP_W_IDLE, PWP_W_RESP} pwp_wstate_t;

  pwp_wstate_t wst_q, wst_d;
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [5:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic bvalid_q, bvalid_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  pwp_pkg::pwp_rd_t rd_q, rd_d;
  logic [31:0] p0_q, p1_q, p2_q;
  logic [31:0] st0, st1, st2;
  pwp_pkg::pwp_wr_t wr0, wr1, wr2;
  logic [31:0] wmask;
  logic do_write;

  // byte lanes gate which bits a write touches
  always_comb begin
    wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  end

  assign do_write = (wst_q == PWP_W_IDLE) && aw_have_q && w_have_q;

  // address and data taken in either order; response after both
  always_comb begin
    wst_d = wst_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    awready_d = 1'b0;
    wready_d = 1'b0;
    wr0 = '0;
    wr1 = '0;
    wr2 = '0;
    case (wst_q)
      PWP_W_IDLE: begin
        if (s_axi_awvalid && awready_q) begin
          aw_have_d = 1'b1;
          awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
          w_have_d = 1'b1;
          wdata_d = s_axi_wdata;
          wstrb_d = s_axi_wstrb;
        end
        awready_d = !aw_have_d && !(s_axi_awvalid && awready_q);
        wready_d = !w_have_d && !(s_axi_wvalid && wready_q);
        if (do_write) begin
          bresp_d = pwp_pkg::PWP_RESP_SLVERR;
          if (awaddr_q[5:4] == pwp_pkg::PWP_GRP0 &&
              awaddr_q[3:0] == pwp_pkg::PWP_OFF_CLEAR) begin
            wr0.clr = 1'b1;
            bresp_d = pwp_pkg::PWP_RESP_OKAY;
          end else if (awaddr_q[5:4] == pwp_pkg::PWP_GRP1 &&
                       awaddr_q[3:0] == pwp_pkg::PWP_OFF_CLEAR) begin
            wr1.clr = 1'b1;
            bresp_d = pwp_pkg::PWP_RESP_OKAY;
          end else if (awaddr_q[5:4] == pwp_pkg::PWP_GRP1 &&
                       awaddr_q[3:0] == pwp_pkg::PWP_OFF_SET) begin
            wr1.set = 1'b1;
            bresp_d = pwp_pkg::PWP_RESP_OKAY;
          end else if (awaddr_q[5:4] == pwp_pkg::PWP_GRP2 &&
                       awaddr_q[3:0] == pwp_pkg::PWP_OFF_CLEAR) begin
            wr2.clr = 1'b1;
            bresp_d = pwp_pkg::PWP_RESP_OKAY;
          end
          aw_have_d = 1'b0;
          w_have_d = 1'b0;
          awready_d = 1'b0;
          wready_d = 1'b0;
          wst_d = PWP_W_RESP;
        end
      end
      PWP_W_RESP: begin
        if (s_axi_bready) begin
          wst_d = PWP_W_IDLE;
          awready_d = 1'b1;
          wready_d = 1'b1;
        end
      end
      default: begin
        wst_d = PWP_W_IDLE;
      end
    endcase
    wr0.data = wdata_q & wmask;
    wr1.data = wdata_q & wmask;
    wr2.data = wdata_q & wmask;
    // registered so the response valid leaves a flop, not a state decode
    bvalid_d = (wst_d == PWP_W_RESP);
  end

  // unmapped reads return zero with an error response
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rd_d = rd_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rd_d.data = 32'h00000000;
      rd_d.resp = pwp_pkg::PWP_RESP_SLVERR;
      if (s_axi_araddr[5:4] == pwp_pkg::PWP_GRP0 &&
          s_axi_araddr[3:0] == pwp_pkg::PWP_OFF_CLEAR) begin
        rd_d.data = st0;
        rd_d.resp = pwp_pkg::PWP_RESP_OKAY;
      end else if (s_axi_araddr[5:4] == pwp_pkg::PWP_GRP1 &&
                   (s_axi_araddr[3:0] == pwp_pkg::PWP_OFF_CLEAR ||
                    s_axi_araddr[3:0] == pwp_pkg::PWP_OFF_SET)) begin
        rd_d.data = st1;
        rd_d.resp = pwp_pkg::PWP_RESP_OKAY;
      end else if (s_axi_araddr[5:4] == pwp_pkg::PWP_GRP2 &&
                   s_axi_araddr[3:0] == pwp_pkg::PWP_OFF_CLEAR) begin
        rd_d.data = st2;
        rd_d.resp = pwp_pkg::PWP_RESP_OKAY;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= PWP_W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= 2'h0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rd_q <= '0;
      p0_q <= pwp_pkg::PWP_G0_RESET;
      p1_q <= pwp_pkg::PWP_G1_RESET;
      p2_q <= pwp_pkg::PWP_G2_RESET;
    end else begin
      wst_q <= wst_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      bvalid_q <= bvalid_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rd_q <= rd_d;
      p0_q <= st0;
      p1_q <= st1;
      p2_q <= st2;
    end
  end

  // the mask fixes which bits exist; the rest read zero
  pwp_group #(.MASK(pwp_pkg::PWP_G0_MASK), .RESET_VAL(pwp_pkg::PWP_G0_RESET)) u_grp0 (
    .aclk(aclk), .aresetn(aresetn), .wr(wr0), .prot(st0));
  pwp_group #(.MASK(pwp_pkg::PWP_G1_MASK), .RESET_VAL(pwp_pkg::PWP_G1_RESET)) u_grp1 (
    .aclk(aclk), .aresetn(aresetn), .wr(wr1), .prot(st1));
  pwp_group #(.MASK(pwp_pkg::PWP_G2_MASK), .RESET_VAL(pwp_pkg::PWP_G2_RESET)) u_grp2 (
    .aclk(aclk), .aresetn(aresetn), .wr(wr2), .prot(st2));

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rd_q.data;
  assign s_axi_rresp = rd_q.resp;
  assign prot_group0 = p0_q;
  assign prot_group1 = p1_q;
  assign prot_group2 = p2_q;

  property p_g0_reset;
    @(posedge aclk) $rose(aresetn) |-> st0 == pwp_pkg::PWP_G0_RESET;
  endproperty
  a_g0_reset: assert property (p_g0_reset) else $error("group0 reset");
  property p_g1_reset;
    @(posedge aclk) $rose(aresetn) |-> st1 == pwp_pkg::PWP_G1_RESET;
  endproperty
  a_g1_reset: assert property (p_g1_reset) else $error("group1 reset");
  property p_zero_keeps;
    @(posedge aclk) disable iff (!aresetn)
      wr1.set |=> (st1 & ~$past(wr1.data)) == ($past(st1) & ~$past(wr1.data));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero bit changed");
  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr0.clr |=> (st0 & $past(wr0.data)) == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_set;
    @(posedge aclk) disable iff (!aresetn)
      wr1.set |=> (st1 & $past(wr1.data) & 32'h0000004E) == ($past(wr1.data) & 32'h0000004E);
  endproperty
  a_set: assert property (p_set) else $error("set failed");
  property p_g0_bits;
    @(posedge aclk) disable iff (!aresetn) (st0 & ~pwp_pkg::PWP_G0_MASK) == 32'h0;
  endproperty
  a_g0_bits: assert property (p_g0_bits) else $error("group0 stray bit");
  property p_g1_bits;
    @(posedge aclk) disable iff (!aresetn) (st1 & ~pwp_pkg::PWP_G1_MASK) == 32'h0;
  endproperty
  a_g1_bits: assert property (p_g1_bits) else $error("group1 stray bit");
  property p_g2_bits;
    @(posedge aclk) disable iff (!aresetn) (st2 & ~pwp_pkg::PWP_G2_MASK) == 32'h0;
  endproperty
  a_g2_bits: assert property (p_g2_bits) else $error("group2 stray bit");
  property p_g2_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr2.clr |=> (st2 & $past(wr2.data)) == 32'h0;
  endproperty
  a_g2_clear: assert property (p_g2_clear) else $error("group2 clear");
  property p_set_read;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && arready_q && s_axi_araddr == 6'h14) |=> rd_q.data == $past(st1);
  endproperty
  a_set_read: assert property (p_set_read) else $error("set read mismatch");
  property p_debug_reset;
    @(posedge aclk) $rose(aresetn) |-> st1[pwp_pkg::PWP_G1_DEBUG_UNIT];
  endproperty
  a_debug_reset: assert property (p_debug_reset) else $error("debug bit not set");
  property p_set_keeps_ones;
    @(posedge aclk) disable iff (!aresetn) wr1.set |=> ($past(st1) & ~st1) == 32'h00000000;
  endproperty
  a_set_keeps_ones: assert property (p_set_keeps_ones) else $error("set cleared a bit");
  property p_clear_adds_none;
    @(posedge aclk) disable iff (!aresetn) wr1.clr |=> (st1 & ~$past(st1)) == 32'h00000000;
  endproperty
  a_clear_adds_none: assert property (p_clear_adds_none) else $error("clear raised a bit");
  property p_state_out;
    @(posedge aclk) disable iff (!aresetn)
      prot_group0 == $past(st0) && prot_group1 == $past(st1) && prot_group2 == $past(st2);
  endproperty
  a_state_out: assert property (p_state_out) else $error("state port lags wrongly");
  property p_write_answers;
    @(posedge aclk) disable iff (!aresetn) do_write |=> s_axi_bvalid;
  endproperty
  a_write_answers: assert property (p_write_answers) else $error("no write response");
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_set: cover property (@(posedge aclk) wr1.set && wr1.data[1]);
  c_clear: cover property (@(posedge aclk) wr1.clr && wr1.data[pwp_pkg::PWP_G1_IO_PINS]);
endmodule // pwp_ctrl
`default_nettype wire

// ===== sim/peripheral_write_protect_ctrl_bench.sv
/*
  self-checking bench for pwp_ctrl: reset values, then a table of
  write/read-back rows, refused addresses and a reset in mid-run.
  assumes the design's own assertions and the AXI4-Lite timing of pwp_ctrl.
*/
`timescale 1ns/1ns
`default_nettype none
module peripheral_write_protect_ctrl_bench;
  typedef struct packed {
    logic [5:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [5:0] ra;
    logic [31:0] ex;
  } pwp_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got, g0, g1, g2;
  int failures = 0, comparisons = 0, cycles = 0;
  pwp_row_t rows [9] = '{
    '{6'h14, 32'h0000004E, 4'hF, 6'h10, 32'h0000004E},
    '{6'h10, 32'h00000000, 4'hF, 6'h14, 32'h0000004E},
    '{6'h10, 32'h00000008, 4'hF, 6'h14, 32'h00000046},
    '{6'h10, 32'h00000040, 4'hF, 6'h10, 32'h00000006},
    '{6'h14, 32'hFFFFFFFF, 4'hF, 6'h14, 32'h0000004E},
    '{6'h00, 32'h0000007E, 4'hF, 6'h00, 32'h00000000},
    '{6'h20, 32'h0001FFFE, 4'hF, 6'h20, 32'h00000000},
    '{6'h10, 32'hFFFFFFFF, 4'h0, 6'h10, 32'h0000004E},
    '{6'h10, 32'h0000004C, 4'h1, 6'h14, 32'h00000002}};

  pwp_ctrl i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prot_group0(g0), .prot_group1(g1), .prot_group2(g2));

  always #25 aclk = ~aclk;

  // guards every handshake wait; the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // readies are captured on the falling edge, where they are settled, and
  // acted on at the following rising edge
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ar, wr, bv, ad, wd;
    logic [1:0] bs;
    begin
      ad = 0;
      wd = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(negedge aclk);
        ar = awready;
        wr = wready;
        bv = bvalid;
        bs = bresp;
        @(posedge aclk);
        if (ar === 1'b1 && !ad) begin
          awvalid <= 1'b0;
          ad = 1;
        end
        if (wr === 1'b1 && !wd) begin
          wvalid <= 1'b0;
          wd = 1;
        end
      end while (bv !== 1'b1);
      bready <= 1'b0;
      resp = bs;
    end
  endtask

  task automatic axr(input logic [5:0] a);
    logic ar, rv, ad;
    begin
      ad = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(negedge aclk);
        ar = arready;
        rv = rvalid;
        got = rdata;
        resp = rresp;
        @(posedge aclk);
        if (ar === 1'b1 && !ad) begin
          arvalid <= 1'b0;
          ad = 1;
        end
      end while (rv !== 1'b1);
      rready <= 1'b0;
    end
  endtask

  // read back and compare data, response and the matching state port
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    begin
      axr(a);
      chk(got, exp);
      chk({30'h0, resp}, {30'h0, pwp_pkg::PWP_RESP_OKAY});
      @(negedge aclk);
      chk(a[5:4] == 2'h0 ? g0 : a[5:4] == 2'h1 ? g1 : g2, exp);
      @(posedge aclk);
    end
  endtask

  task automatic do_reset();
    begin
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    do_reset();
    rdchk(6'h00, pwp_pkg::PWP_G0_RESET);
    rdchk(6'h10, 32'h00000002);
    rdchk(6'h14, 32'h00000002);
    rdchk(6'h20, pwp_pkg::PWP_G2_RESET);
    // rows run back to back, each state depending on the one before
    foreach (rows[i]) begin
      axw(rows[i].wa, rows[i].wd, rows[i].ws);
      chk({30'h0, resp}, {30'h0, pwp_pkg::PWP_RESP_OKAY});
      rdchk(rows[i].ra, rows[i].ex);
    end
    // group0 has no set register: a write there is refused and changes nothing
    axw(6'h04, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, resp}, {30'h0, pwp_pkg::PWP_RESP_SLVERR});
    rdchk(6'h00, 32'h00000000);
    axw(6'h30, 32'hFFFFFFFF, 4'hF);
    chk({30'h0, resp}, {30'h0, pwp_pkg::PWP_RESP_SLVERR});
    axr(6'h30);
    chk(got, 32'h0);
    chk({30'h0, resp}, {30'h0, pwp_pkg::PWP_RESP_SLVERR});
    // reset in mid-run must bring protection back to its reset state
    axw(6'h14, 32'h0000004E, 4'hF);
    rdchk(6'h14, 32'h0000004E);
    do_reset();
    rdchk(6'h10, 32'h00000002);
    conclude();
  end
endmodule // peripheral_write_protect_ctrl_bench
`default_nettype wire
